// [hdl/srba_core.sv]
// Command decode, refresh, posted column timing and burst data path of the memory
`timescale 1ns/1ns
`default_nettype none

// What this block does and what its controller must keep to
// [R1] Refresh ignores address; row from internal counter
// [R2] Controller issues every refresh; none repeated internally
// [R3] After refresh every bank is precharged idle
// [R4] Controller waits refresh cycle time after refresh
// [R5] At most eight refreshes postponed by controller
// [R6] Chip-selected all-high command does nothing
// [R7] Deselect disables decoder; other pins ignored
// [R8] Bursts stay inside aligned group of start
// [R9] Controller interrupts only long same-type bursts
// [R10] Column commands at least two clocks apart
// [R11] Column command held posted delay before execution
// [R12] Early column commands need nonzero posted delay
// [R13] Read latency posted plus column; write one less
// [R14] Only lengths four and eight; type bit
// [R15] No burst stop; bursts run full length
// [R16] Short burst: wrap or XOR low bits
// [R17] Long burst: nibble wrap or XOR order
// [R18] First read beat at latency after preamble
// [R19] Later read beats follow each strobe edge
// [R20] Controller strobes write data after preamble
// [R21] Extra write data after last beat ignored
// [R22] Controller waits write recovery before precharge
// [R23] Posted delay spans zero through six
// [R24] Long burst interrupt exactly two clocks later
// [R25] Refresh row counter advances and wraps
module srba_core
  import srba_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             mem_ck,
  input  wire srba_pins_t       cmd_pins,
  input  wire logic [DQ_W-1:0]  dq_in,
  output logic [DQ_W-1:0]       dq_out,
  output logic                  dq_oe,
  input  wire logic             dqs_in,
  output logic                  dqs_out,
  output logic                  dqs_oe,
  input  wire logic [2:0]       cas_latency,
  input  wire logic [2:0]       posted_delay,
  input  wire logic [2:0]       burst_len_code,
  input  wire logic             burst_interleave,
  output logic                  refresh_pulse,
  output logic [ROW_W-1:0]      refresh_row,
  output logic [3:0]            bank_open,
  output logic                  col_exec,
  output logic                  col_exec_write,
  output logic [3:0]            read_latency,
  output logic [3:0]            write_latency
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic            ck_m;      // First stage of the link clock
  logic            ck_s;      // Synchronised link clock
  logic            ck_q;      // Previous synchronised link clock
  srba_pins_t      pins_m;    // First stage of command pins
  srba_pins_t      pins_s;    // Synchronised command pins
  logic [DQ_W-1:0] dq_m;      // First stage of data pins
  logic [DQ_W-1:0] dq_s;      // Synchronised data pins
  logic            dqs_m;     // First stage of the strobe
  logic            dqs_s;     // Synchronised strobe
  logic            dqs_q;     // Previous synchronised strobe

  // All pins pass the same two stages, so their relative timing is kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ck_m   <= 1'b0;
      ck_s   <= 1'b0;
      ck_q   <= 1'b0;
      pins_m <= '0;
      pins_s <= '0;
      dq_m   <= '0;
      dq_s   <= '0;
      dqs_m  <= 1'b0;
      dqs_s  <= 1'b0;
      dqs_q  <= 1'b0;
    end else begin
      ck_m   <= mem_ck;
      ck_s   <= ck_m;
      ck_q   <= ck_s;
      pins_m <= cmd_pins;
      pins_s <= pins_m;
      dq_m   <= dq_in;
      dq_s   <= dq_m;
      dqs_m  <= dqs_in;
      dqs_s  <= dqs_m;
      dqs_q  <= dqs_s;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and command decode
  // ----------------------------------------------------------------
  logic       ck_rise;    // Link clock rising edge seen
  logic       ck_edge;    // Either link clock edge seen
  logic       dqs_rise;   // Strobe rising edge seen
  logic       dqs_edge;   // Either strobe edge seen
  logic       sel;        // A command is sampled this cycle
  logic [2:0] code;       // Row, column and write strobes
  logic       is_ref;     // Refresh
  logic       is_act;     // Activate
  logic       is_pre;     // Precharge
  srba_col_t  new_col;    // Column command just taken
  logic       bl8;        // Long bursts selected
  logic [2:0] al;         // Posted delay in use
  logic [2:0] cl;         // Column latency in use
  logic [3:0] rl;         // Read latency in link clocks
  logic [3:0] wl;         // Write latency in link clocks
  logic [3:0] ins_idx;    // Line slot for the new command

  assign ck_rise  = ck_s & ~ck_q;
  assign ck_edge  = ck_s ^ ck_q;
  assign dqs_rise = dqs_s & ~dqs_q;
  assign dqs_edge = dqs_s ^ dqs_q;

  // A deselected cycle drops out here, before any strobe is looked at
  assign sel  = ck_rise & ~pins_s.cs_n & pins_s.cke;  // R7
  assign code = {pins_s.ras_n, pins_s.cas_n, pins_s.we_n};

  // All-high, burst stop and unlisted codes fall through as no operation
  always_comb begin
    is_ref        = sel & (code == CMD_REF);  // R1
    is_act        = sel & (code == CMD_ACT);
    is_pre        = sel & (code == CMD_PRE);
    new_col.valid = sel & ((code == CMD_RD) | (code == CMD_WR));  // R6 R15
    new_col.write = (code == CMD_WR);
    new_col.bank  = pins_s.ba;
    new_col.col   = pins_s.addr[COL_W-1:0];
  end

  // Latency arithmetic; out-of-range settings are clamped
  always_comb begin
    bl8     = (burst_len_code == BL_CODE_8);  // R14
    al      = (posted_delay > AL_MAX) ? AL_MAX : posted_delay;  // R23
    cl      = (cas_latency < CL_MIN) ? CL_MIN : cas_latency;
    rl      = {1'b0, al} + {1'b0, cl};  // R13
    wl      = rl - 4'h1;  // R13
    ins_idx = (new_col.write ? wl : rl) - 4'h1;
  end

  // Latencies in use, shown for software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_latency  <= 4'h0;
      write_latency <= 4'h0;
    end else begin
      read_latency  <= rl;
      write_latency <= wl;
    end
  end

  // ----------------------------------------------------------------
  // Refresh and bank state
  // ----------------------------------------------------------------
  logic [ROW_W-1:0] ref_ctr;   // Row for the next refresh

  // Refresh takes its row from the counter, never from the pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_ctr       <= ROW_RESET;
      refresh_row   <= ROW_RESET;
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= is_ref;
      if (is_ref) begin
        refresh_row <= ref_ctr;  // R1
        ref_ctr     <= (ref_ctr == ROW_LAST) ? ROW_RESET : ref_ctr + 13'h0001;  // R25
      end
    end
  end

  // Open banks; refresh leaves them all closed
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bank_open <= 4'h0;
    end else if (is_ref) begin
      bank_open <= 4'h0;  // R3
    end else if (is_act) begin
      bank_open[pins_s.ba] <= 1'b1;
    end else if (is_pre) begin
      if (pins_s.addr[AP_BIT]) begin
        bank_open <= 4'h0;
      end else begin
        bank_open[pins_s.ba] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Posted command line
  // ----------------------------------------------------------------
  srba_col_t line [LINE_D];   // Slot 0 starts its burst at the next link rise

  // Shifts once per link clock; a command lands where its latency runs out at slot 0
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < LINE_D; i++) begin
        line[i] <= '0;
      end
    end else if (ck_rise) begin
      for (int i = 0; i < LINE_D - 1; i++) begin
        line[i] <= line[i+1];
      end
      line[LINE_D-1] <= '0;
      if (new_col.valid) begin
        line[ins_idx] <= new_col;  // R11 R13
      end
    end
  end

  // Internal column execution, posted delay after the command; writes sit one slot lower
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      col_exec       <= 1'b0;
      col_exec_write <= 1'b0;
    end else begin
      col_exec <= 1'b0;
      if (ck_rise && al == 3'h0 && new_col.valid) begin
        col_exec       <= 1'b1;
        col_exec_write <= new_col.write;
      end else if (ck_rise && ((line[cl].valid && !line[cl].write) || line[cl-3'h1].write)) begin
        col_exec       <= 1'b1;  // R11
        col_exec_write <= line[cl-3'h1].write;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage array
  // ----------------------------------------------------------------
  // Rows are not modelled: one page per bank is held
  logic [DQ_W-1:0] mem [4 << COL_W];
  srba_beat_t      drain_word;    // Beat leaving the buffer
  logic            drain_valid;   // Buffer holds a beat
  logic            drain_ready;   // Array free to take it

  // Link edges reserve the array for read fetches, so the buffer may stall
  assign drain_ready = ~ck_edge;

  always_ff @(posedge clk) begin
    if (drain_valid && drain_ready) begin
      mem[{drain_word.bank, drain_word.col}] <= drain_word.data;
    end
  end

  // ----------------------------------------------------------------
  // Read engine
  // ----------------------------------------------------------------
  srba_rd_state_t   rd_state;   // Read engine state
  logic [3:0]       rd_beat;    // Beat now on the pins
  logic [3:0]       rd_len;     // Beats in this burst
  logic [BA_W-1:0]  rd_bank;    // Bank of this burst
  logic [COL_W-1:0] rd_col;     // Starting column
  logic             rd_bl8;     // Order taken at start
  logic             rd_ilv;     // Interleave taken at start
  logic [COL_W-1:0] rd_next;    // Column of the following beat

  assign rd_next = srba_burst_col(rd_col, rd_beat[2:0] + 3'h1, rd_bl8, rd_ilv);  // R16 R17 R8

  // A new read at slot 0 replaces any running read, which is how interrupts land
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_state <= RD_IDLE;
      rd_beat  <= 4'h0;
      rd_len   <= LEN_4;
      rd_bank  <= '0;
      rd_col   <= '0;
      rd_bl8   <= 1'b0;
      rd_ilv   <= 1'b0;
      dq_out   <= '0;
      dq_oe    <= 1'b0;
      dqs_out  <= 1'b0;
      dqs_oe   <= 1'b0;
    end else if (ck_rise && line[0].valid && !line[0].write) begin
      // First beat on the strobe's first rise
      rd_state <= RD_BURST;
      rd_beat  <= 4'h0;
      rd_len   <= bl8 ? LEN_8 : LEN_4;  // R14
      rd_bank  <= line[0].bank;
      rd_col   <= line[0].col;
      rd_bl8   <= bl8;
      rd_ilv   <= burst_interleave;
      dq_out   <= mem[{line[0].bank, line[0].col}];  // R18
      dq_oe    <= 1'b1;
      dqs_out  <= 1'b1;
      dqs_oe   <= 1'b1;
    end else if (ck_edge && rd_state == RD_BURST && rd_beat != rd_len - 4'h1) begin
      // Each link edge carries the next beat with a strobe transition
      rd_beat <= rd_beat + 4'h1;
      dq_out  <= mem[{rd_bank, rd_next}];  // R19
      dqs_out <= ck_rise;  // R19
    end else if (ck_rise) begin
      // Burst over, or idle; start the preamble when a read is one clock away
      dq_oe   <= 1'b0;
      dqs_out <= 1'b0;
      if (line[1].valid && !line[1].write) begin
        rd_state <= RD_PRE;
        dqs_oe   <= 1'b1;  // R18
      end else begin
        rd_state <= RD_IDLE;
        dqs_oe   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write engine
  // ----------------------------------------------------------------
  logic             wr_active;    // Capture window open
  logic [3:0]       wr_beat;      // Beats captured so far
  logic [3:0]       wr_len;       // Beats expected
  logic [BA_W-1:0]  wr_bank;      // Bank of this burst
  logic [COL_W-1:0] wr_col;       // Starting column
  logic             wr_bl8;       // Order taken at start
  logic             wr_ilv;       // Interleave taken at start
  srba_beat_t       cap;          // Beat waiting for the buffer
  logic             cap_valid;    // Beat waiting
  logic             cap_ready;    // Buffer takes it
  logic             cap_free;     // Capture register can load
  logic             wr_restart;   // Write reaches slot 0
  logic             wr_arm;       // Write one clock away
  logic             wr_take;      // Capture a beat now

  // Arming one clock early keeps the first strobe rise from racing the link rise;
  // a restart only cuts a burst that has delivered at least two beats
  always_comb begin
    cap_free   = ~cap_valid | cap_ready;
    wr_restart = ck_rise & line[0].valid & line[0].write &
                 (~wr_active | (wr_beat >= WR_RESTART));
    wr_arm     = ck_rise & line[1].valid & line[1].write & ~wr_active & ~wr_restart;
    wr_take    = wr_active & dqs_edge & cap_free & ((wr_beat != 4'h0) | dqs_rise);
  end

  // Beats are caught on strobe edges until the programmed count is met
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_active <= 1'b0;
      wr_beat   <= 4'h0;
      wr_len    <= LEN_4;
      wr_bank   <= '0;
      wr_col    <= '0;
      wr_bl8    <= 1'b0;
      wr_ilv    <= 1'b0;
      cap       <= '0;
      cap_valid <= 1'b0;
    end else begin
      if (cap_ready) begin
        cap_valid <= 1'b0;
      end
      if (wr_restart || wr_arm) begin
        wr_active <= 1'b1;
        wr_beat   <= 4'h0;
        wr_len    <= bl8 ? LEN_8 : LEN_4;  // R14
        wr_bank   <= wr_restart ? line[0].bank : line[1].bank;
        wr_col    <= wr_restart ? line[0].col : line[1].col;
        wr_bl8    <= bl8;
        wr_ilv    <= burst_interleave;
        if (wr_restart && dqs_rise && cap_free) begin
          cap       <= '{bank: line[0].bank, col: line[0].col, data: dq_s};
          cap_valid <= 1'b1;
          wr_beat   <= 4'h1;
        end
      end else if (wr_take) begin
        cap.bank  <= wr_bank;
        cap.col   <= srba_burst_col(wr_col, wr_beat[2:0], wr_bl8, wr_ilv);  // R16 R17 R8
        cap.data  <= dq_s;
        cap_valid <= 1'b1;
        wr_beat   <= wr_beat + 4'h1;
        if (wr_beat + 4'h1 == wr_len) begin
          wr_active <= 1'b0;  // R21
        end
      end
    end
  end

  // Captured beats queue for the array
  srba_fifo2 #(
    .W ($bits(srba_beat_t))
  ) u_wbuf (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (cap),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_word)
  );

endmodule

`default_nettype wire

// [hdl/srba_fifo2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module srba_fifo2
  import srba_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [W-1:0] slot [2];   // Entries
  logic         wptr;       // Next slot to fill
  logic         rptr;       // Next slot to drain
  logic [1:0]   count;      // Entries held
  logic         push;       // Accepted on the filling side
  logic         pop;        // Taken on the draining side

  assign in_ready  = (count != FIFO_FULL);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers and fill level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr  <= 1'b0;
      rptr  <= 1'b0;
      count <= 2'h0;
    end else begin
      wptr  <= wptr ^ push;
      rptr  <= rptr ^ pop;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Data slots carry no reset; valid alone qualifies them
  always_ff @(posedge clk) begin
    if (push) begin
      slot[wptr] <= in_data;
    end
  end

endmodule

`default_nettype wire

// [include/srba_pkg.sv]
// Shared constants, types and the burst order function for the memory access block
package srba_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DQ_W   = 16;   // Data pins
  localparam int COL_W  = 9;    // Column address bits in a page
  localparam int ROW_W  = 13;   // Row address bits
  localparam int BA_W   = 2;    // Bank select bits
  localparam int ADDR_W = 13;   // Address pins
  localparam int LINE_D = 16;   // Depth of the posted command line
  localparam int AP_BIT = 10;   // Address bit that selects precharge of all banks

  // ----------------------------------------------------------------
  // Configuration codes, limits and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] BL_CODE_8   = 3'h3;    // Burst length eight code
  localparam logic [2:0] AL_MAX      = 3'h6;    // Largest posted delay
  localparam logic [2:0] CL_MIN      = 3'h2;    // Smallest column latency taken
  localparam logic [3:0] LEN_4       = 4'h4;    // Beats in a short burst
  localparam logic [3:0] LEN_8       = 4'h8;    // Beats in a long burst
  localparam logic [3:0] WR_RESTART  = 4'h2;    // Beats after which a write may restart
  localparam logic [1:0] FIFO_FULL   = 2'h2;    // Entries in the write buffer
  localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;  // Refresh row after reset
  localparam logic [ROW_W-1:0] ROW_LAST  = 13'h1fff;  // Last row before wrap

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Command pins sampled together
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } srba_pins_t;

  // A posted column command
  typedef struct packed {
    logic             valid;
    logic             write;
    logic [BA_W-1:0]  bank;
    logic [COL_W-1:0] col;
  } srba_col_t;

  // One captured write beat
  typedef struct packed {
    logic [BA_W-1:0]  bank;
    logic [COL_W-1:0] col;
    logic [DQ_W-1:0]  data;
  } srba_beat_t;

  // Command codes of {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_NOP = 3'h7
  } srba_cmd_t;

  // Read data engine states
  typedef enum logic [1:0] {RD_IDLE, RD_PRE, RD_BURST} srba_rd_state_t;

  // Column of a given beat; upper bits never change, so bursts stay in their group
  function automatic logic [COL_W-1:0] srba_burst_col(input logic [COL_W-1:0] start,
                                                      input logic [2:0] beat,
                                                      input logic bl8,
                                                      input logic ilv);
    logic [2:0] low;
    low = start[2:0] ^ beat;
    if (!ilv) begin
      low[1:0] = start[1:0] + beat[1:0];
    end
    if (!bl8) begin
      low[2] = start[2];
    end
    return {start[COL_W-1:3], low};
  endfunction

endpackage

// [verification/srba_core_props.sv]
// Port checker for the memory command and burst block
`timescale 1ns/1ns
`default_nettype none
module srba_core_props
  import srba_pkg::*;
(
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic [2:0]       cas_latency,
  input wire logic [2:0]       posted_delay,
  input wire logic             refresh_pulse,
  input wire logic [ROW_W-1:0] refresh_row,
  input wire logic [3:0]       bank_open,
  input wire logic             col_exec,
  input wire logic [3:0]       read_latency,
  input wire logic [3:0]       write_latency,
  input wire logic             dq_oe,
  input wire logic             dqs_out,
  input wire logic             dqs_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic       seen;    // A refresh has already happened
  logic [3:0] exp_rl;  // Clamped latency sum
  // The very first refresh repeats the reset row, so skip it
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) seen <= 1'b0;
    else if (refresh_pulse) seen <= 1'b1;
  always_comb exp_rl = 4'(cas_latency < CL_MIN ? CL_MIN : cas_latency)
                     + 4'(posted_delay > AL_MAX ? AL_MAX : posted_delay);
  sequence preamble;
    dqs_oe && !dq_oe && !dqs_out;
  endsequence
  sequence first_beat;
    dq_oe && dqs_out;
  endsequence
  AST_REF_ROW: assert property (refresh_pulse && seen |-> refresh_row == $past(refresh_row) + 13'h1)
    else $error("refresh row did not step by one");
  AST_REF_IDLE: assert property (refresh_pulse |-> bank_open == 4'h0)
    else $error("bank left open after refresh");
  AST_PULSE: assert property (refresh_pulse || col_exec |=> !(refresh_pulse || col_exec) [*8])
    else $error("pulse longer than one cycle");
  AST_RL: assert property (read_latency != 4'h0 |-> read_latency == $past(exp_rl))
    else $error("read latency wrong");
  AST_WL: assert property (read_latency != 4'h0 |-> write_latency == read_latency - 4'h1)
    else $error("write latency wrong");
  AST_PRE: assert property ($rose(dqs_oe) |-> preamble ##[12:13] first_beat)
    else $error("read preamble wrong");
  AST_BEAT: assert property ($rose(dqs_out) && dq_oe |-> ##[6:7] ($fell(dqs_out) && dq_oe))
    else $error("read beat off strobe");
  AST_OE: assert property (dq_oe |-> dqs_oe)
    else $error("data without strobe");
  AST_FULL: assert property ($rose(dq_oe) |-> dq_oe [*8])
    else $error("read burst cut short");
endmodule
bind srba_core srba_core_props srba_core_props_i (.clk, .resetn, .cas_latency, .posted_delay,
  .refresh_pulse, .refresh_row, .bank_open, .col_exec, .read_latency, .write_latency, .dq_oe,
  .dqs_out, .dqs_oe);
`default_nettype wire

// [verification/srba_core_tb.sv]
// Self-checking bench for the memory command and burst block
`timescale 1ns/1ns
`default_nettype none
module srba_core_tb
  import srba_pkg::*;
;
  logic             clk, resetn, mem_ck, m_dqs, dqs_in, dqs_out, dqs_oe, dq_oe, pdqs;
  logic             refresh_pulse, bl8, ilv;
  logic [2:0]       cas_latency, posted_delay;
  logic [3:0]       bank_open, read_latency, write_latency;
  logic [DQ_W-1:0]  m_dq, dq_in, dq_out, mem [8], d [10];
  logic [ROW_W-1:0] refresh_row;
  logic [8:0]       base;
  logic [1:0]       b;
  srba_pins_t       pins;
  logic [DQ_W-1:0]  got [$];
  int               bad_count, checks, nref, cyc, rl, s;
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // Shared wires: whoever enables drives
  assign dq_in = dq_oe ? dq_out : m_dq;
  assign dqs_in = dqs_oe ? dqs_out : m_dqs;
  srba_ctrl_model srba_ctrl_model_i (.mem_ck, .pins, .dq(m_dq), .dqs(m_dqs));
  srba_core srba_core_i (.clk, .resetn, .mem_ck, .cmd_pins(pins), .dq_in, .dq_out, .dq_oe,
    .dqs_in, .dqs_out, .dqs_oe, .cas_latency, .posted_delay,
    .burst_len_code(bl8 ? BL_CODE_8 : 3'h2), .burst_interleave(ilv), .refresh_pulse,
    .refresh_row, .bank_open, .col_exec(), .col_exec_write(), .read_latency, .write_latency);
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, refresh watch and read beat capture on each strobe change
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (refresh_pulse === 1'b1) begin
      chk(refresh_row === ROW_W'(nref) && bank_open === 4'h0, "refresh row or banks");
      nref++;
    end
    if (dq_oe === 1'b1 && dqs_out !== pdqs) got.push_back(dq_out);
    pdqs <= dqs_out;
    if (cyc == 20000) begin
      bad_count++;
      stop_test;
    end
  end
  // Expected column offset of a beat inside its aligned group
  function automatic int ord(int st, int n);
    return ilv ? (st ^ n) & 7 : ((st ^ n) & 4) | ((st + n) & 3);
  endfunction
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a);
    srba_ctrl_model_i.cmd(1'b0, c, ba, a, 1'b1);
  endtask
  // Deselected cycles with garbage on every other pin
  task automatic idle(input int n);
    repeat (n) srba_ctrl_model_i.cmd(1'b1, 3'($urandom), 2'($urandom), 13'($urandom), 1'($urandom));
  endtask
  task automatic cfg(input logic l8, input logic il);
    @(posedge clk);
    #1 bl8 = l8;
    ilv = il;
  endtask
  task automatic wr(input int st, input int n);
    cmd(CMD_WR, b, 13'(base | st));
    fork
      srba_ctrl_model_i.burst(rl - 1, n, d);
      idle(rl + 6);
    join
  endtask
  initial begin
    resetn = 1'b0;
    cas_latency = 3'h3;
    posted_delay = 3'h1;
    bl8 = 1'b1;
    ilv = 1'b0;
    pdqs = 1'b0;
    rl = $urandom(10);
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    // Refresh with stray address after an activate and a no-operation
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_ACT, 2'(i), 13'($urandom));
      cmd(CMD_NOP, 2'($urandom), 13'($urandom));
      #50 chk(bank_open === 4'h1 << i, "open bank lost");
      cmd(CMD_REF, 2'($urandom), 13'($urandom));
      idle(8);
    end
    chk(nref == 3, "refresh count");
    $display("refresh test done");
    // Long write, optional short overwrite with extra beats, read in each mode
    for (int t = 0; t < 12; t++) begin
      cfg(1'b1, 1'b0);
      posted_delay = 3'($urandom_range(6, 1));
      cas_latency = 3'($urandom_range(6, 2));
      rl = posted_delay + cas_latency;
      b = 2'($urandom);
      base = {6'($urandom), 3'h0};
      foreach (d[j]) d[j] = DQ_W'($urandom);
      foreach (mem[j]) mem[j] = d[j];
      cmd(CMD_ACT, b, 13'($urandom));
      wr(0, 8);
      if (t % 2 == 1) begin
        cfg(1'b0, 1'($urandom));
        s = $urandom_range(7);
        foreach (d[j]) d[j] = DQ_W'($urandom);
        for (int n = 0; n < 4; n++) mem[ord(s, n)] = d[n];
        wr(s, 6);
      end
      cfg(t[1], t[2]);
      s = $urandom_range(7);
      got.delete();
      cmd(CMD_RD, b, 13'(base | s));
      idle(rl + 6);
      for (int n = 0; n < (bl8 ? 8 : 4); n++)
        chk(got.size() > n && got[n] === mem[ord(s, n)], "read beat");
      chk(got.size() == (bl8 ? 8 : 4), "beat count");
      chk(read_latency === 4'(rl) && write_latency === 4'(rl - 1), "latency");
      cmd(CMD_PRE, 2'h0, 13'h400);
      idle(2);
    end
    $display("burst test done");
    stop_test;
  end
endmodule
`default_nettype wire

// [verification/srba_ctrl_model.sv]
// Memory controller model: link clock, command pins and strobed write data
`timescale 1ns/1ns
`default_nettype none
module srba_ctrl_model
  import srba_pkg::*;
(
  output var logic            mem_ck,
  output var srba_pins_t      pins,
  output var logic [DQ_W-1:0] dq,
  output var logic            dqs
);
  // Link clock runs free; odd phase keeps its edges off clk edges
  initial begin
    mem_ck = 1'b0;
    pins = '{cs_n: 1'b1, default: '0};
    dq = '0;
    dqs = 1'b0;
    #2;
    forever begin
      #62 mem_ck <= 1'b1;
      #63 mem_ck <= 1'b0;
    end
  end
  // Pins change at the fall so they are steady across the sampling rise
  task automatic cmd(input logic cs_n, input logic [2:0] c, input logic [1:0] ba,
                     input logic [ADDR_W-1:0] a, input logic cke);
    @(negedge mem_ck) pins <= '{cs_n, c[2], c[1], c[0], cke, ba, a};
    @(posedge mem_ck);
  endtask
  // Write burst; data leads each strobe edge by a quarter clock, released lines invert
  task automatic burst(input int wl, input int n, input logic [DQ_W-1:0] d [10]);
    repeat (wl - 1) @(posedge mem_ck);
    @(negedge mem_ck) dqs <= 1'b0;
    for (int i = 0; i < n; i++) begin
      #31 dq <= d[i];
      @(mem_ck) dqs <= ~dqs;
    end
    #31 dq <= ~dq;
    dqs <= ~dqs;
  endtask
endmodule
`default_nettype wire
